// ==== hdl/mleir_consts.svh ====
// constants for the mode latch and external interrupt block
// assumes inclusion by bare name from package and modules
`ifndef MLEIR_CONSTS_SVH
`define MLEIR_CONSTS_SVH

`define MLEIR_CLK_PERIOD_NS     5
`define MLEIR_PIN_SWAP_NS       100
`define MLEIR_PIN_SWAP_CYC      ((`MLEIR_PIN_SWAP_NS + `MLEIR_CLK_PERIOD_NS - 1) / `MLEIR_CLK_PERIOD_NS)
`define MLEIR_SWAP_CNT_W        8
`define MLEIR_MODE_LATCH_CYC    1
`define MLEIR_MODE_RST          2'h0
`define MLEIR_TRIG_RST          1'b0

`endif

// ==== hdl/mleir_pkg.sv ====
// types for the mode latch and external interrupt block
// assumes mleir_consts.svh is on the include path
package mleir_pkg;
	`include "mleir_consts.svh"

	typedef enum logic {
		MLEIR_TRIG_LEVEL,
		MLEIR_TRIG_FALL
	} mleir_trig_e;

	typedef struct packed {
		logic mode_b;
		logic mode_a;
	} mleir_mode_s;

	typedef enum logic [1:0] {
		MLEIR_ST_RESET,
		MLEIR_ST_SWAP_WAIT,
		MLEIR_ST_IRQ
	} mleir_phase_e;
endpackage

// ==== hdl/mleir_irq_chan.sv ====
// one external interrupt channel: synchroniser, level or falling-edge detect
// assumes pin is asynchronous to clk_sys_in and active low
`timescale 1ns/100ps
module mleir_irq_chan
	import mleir_pkg::*;
(
	input  wire logic        clk_sys_in,   // system clock
	input  wire logic        rst_b_in,     // synchronised reset, active low
	input  wire logic        pin_b_in,     // raw request pin, active low
	input  wire mleir_trig_e trig_in,      // level or falling edge
	input  wire logic        enable_in,    // pin serves as request
	input  wire logic        ack_in,       // clears edge latch
	output logic             sync_b_out,   // synchronised pin level
	output logic             req_out       // pending request
);
	`include "mleir_consts.svh"

	logic meta_b;
	logic sync_b;
	logic prev_b;
	logic edge_pend;
	logic fall;

	// first stage read only by second
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_b <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			meta_b <= pin_b_in;
			sync_b <= meta_b;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prev_b <= 1'b1;
		end else begin
			prev_b <= sync_b;
		end
	end

	assign fall = prev_b & ~sync_b;

	// set wins over ack clear; disable or level trigger clears first
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			edge_pend <= 1'b0;
		end else if (!enable_in || trig_in != MLEIR_TRIG_FALL) begin
			edge_pend <= 1'b0;
		end else if (fall) begin
			edge_pend <= 1'b1;
		end else if (ack_in) begin
			edge_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			req_out <= 1'b0;
		end else if (!enable_in) begin
			req_out <= 1'b0;
		end else if (trig_in == MLEIR_TRIG_LEVEL) begin
			req_out <= ~sync_b;
		end else begin
			req_out <= (edge_pend & ~ack_in) | fall;
		end
	end

	assign sync_b_out = sync_b;
endmodule

// ==== hdl/mleir_top.sv ====
// mode latch, external interrupt pins and reset release
// assumes core and priority logic sit outside; one clock
`timescale 1ns/100ps
module mleir_top
	import mleir_pkg::*;
(
	input  wire logic        clk_sys_in,      // system clock, 200 MHz
	input  wire logic        rst_b_in,        // hardware reset, active low
	input  wire logic        mode_select_a_in, // pin A, mode / ext_irq_a_b
	input  wire logic        mode_select_b_in, // pin B, mode / ext_irq_b_b
	input  wire mleir_trig_e trig_a_in,       // request A trigger type
	input  wire mleir_trig_e trig_b_in,       // request B trigger type
	input  wire logic        ack_a_in,        // core took request A
	input  wire logic        ack_b_in,        // core took request B
	input  wire logic        mode_wr_in,      // software mode write strobe
	input  wire mleir_mode_s mode_wdata_in,   // software mode value
	input  wire logic        stop_in,         // core enters stop state
	output mleir_mode_s      mode_out,        // current operating mode
	output logic             ext_irq_a_out,   // request A pending
	output logic             ext_irq_b_out,   // request B pending
	output logic             stopped_out,     // core held in stop
	output logic             wake_out,        // stop exit pulse
	output logic             core_rst_b_out,  // internal reset, active low
	output logic             pins_irq_out     // pins serve as requests
);
	`include "mleir_consts.svh"

	localparam logic [`MLEIR_SWAP_CNT_W-1:0] SWAP_CYC  = `MLEIR_SWAP_CNT_W'(`MLEIR_PIN_SWAP_CYC);
	localparam logic [`MLEIR_SWAP_CNT_W-1:0] LATCH_CYC = `MLEIR_SWAP_CNT_W'(`MLEIR_MODE_LATCH_CYC);

	logic                         rst_meta_b;
	logic                         rst_sync_b;
	logic                         rst_seen;
	mleir_phase_e                 phase;
	mleir_phase_e                 next_phase;
	logic [`MLEIR_SWAP_CNT_W-1:0] swap_cnt;
	logic                         pins_irq;
	logic                         sync_a_b;
	logic                         sync_b_b;
	logic                         irq_a;
	logic                         irq_b;

	// reset release synchronised to the clock
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	assign core_rst_b_out = rst_sync_b;

	// reset exit phase sequence
	always_comb begin
		next_phase = phase;
		case (phase)
			MLEIR_ST_RESET: begin
				next_phase = MLEIR_ST_SWAP_WAIT;
			end
			MLEIR_ST_SWAP_WAIT: begin
				if (swap_cnt == SWAP_CYC) begin
					next_phase = MLEIR_ST_IRQ;
				end
			end
			MLEIR_ST_IRQ: begin
				next_phase = MLEIR_ST_IRQ;
			end
			default: begin
				next_phase = MLEIR_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			phase <= MLEIR_ST_RESET;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			swap_cnt <= '0;
		end else if (phase == MLEIR_ST_SWAP_WAIT && swap_cnt != SWAP_CYC) begin
			swap_cnt <= swap_cnt + `MLEIR_SWAP_CNT_W'(1);
		end
	end

	assign pins_irq     = (phase == MLEIR_ST_IRQ);
	assign pins_irq_out = pins_irq;

	// mode latch; waits until both synchroniser stages hold pin levels,
	// software may overwrite later
	always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mode_out <= `MLEIR_MODE_RST;
		end else if (phase == MLEIR_ST_SWAP_WAIT && swap_cnt == LATCH_CYC) begin
			mode_out.mode_a <= sync_a_b;
			mode_out.mode_b <= sync_b_b;
		end else if (mode_wr_in) begin
			mode_out <= mode_wdata_in;
		end
	end

	// channel A: synchroniser plus trigger select
	mleir_irq_chan u_chan_a (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_sync_b),
		.pin_b_in   (mode_select_a_in),
		.trig_in    (trig_a_in),
		.enable_in  (pins_irq),
		.ack_in     (ack_a_in),
		.sync_b_out (sync_a_b),
		.req_out    (irq_a)
	);

	// channel B, independent trigger select
	mleir_irq_chan u_chan_b (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_sync_b),
		.pin_b_in   (mode_select_b_in),
		.trig_in    (trig_b_in),
		.enable_in  (pins_irq),
		.ack_in     (ack_b_in),
		.sync_b_out (sync_b_b),
		.req_out    (irq_b)
	);

	assign ext_irq_a_out = irq_a;
	assign ext_irq_b_out = irq_b;

	// stop state: request A wakes the core; wake wins over stop entry
	always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			stopped_out <= 1'b0;
			wake_out    <= 1'b0;
		end else if (stopped_out && irq_a) begin
			stopped_out <= 1'b0;
			wake_out    <= 1'b1;
		end else begin
			wake_out <= 1'b0;
			if (stop_in) begin
				stopped_out <= 1'b1;
			end
		end
	end
endmodule

// ==== verification/mleir_top_props.sv ====
// assertions on the mode latch, request pins and reset release
// assumes bound to mleir_top; one clock domain
`timescale 1ns/100ps
module mleir_top_chk
	import mleir_pkg::*;
(
	input wire logic        clk_sys_in, rst_b_in, mode_select_a_in, mode_select_b_in,
	input wire mleir_trig_e trig_a_in, trig_b_in,
	input wire logic        ack_a_in, ack_b_in, mode_wr_in, stop_in,
	input wire mleir_mode_s mode_wdata_in, mode_out,
	input wire logic        ext_irq_a_out, ext_irq_b_out, stopped_out, wake_out, core_rst_b_out, pins_irq_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_release;
		!core_rst_b_out ##1 !core_rst_b_out ##1 core_rst_b_out;
	endsequence
	sequence s_wake;
		!stopped_out && wake_out ##1 !wake_out;
	endsequence
	AST_IN_RESET: assert property (disable iff (1'b0) !rst_b_in ##1 !rst_b_in |-> !core_rst_b_out && !pins_irq_out)
		else $error("core not held in reset");
	AST_RELEASE: assert property ($rose(rst_b_in) |-> s_release)
		else $error("internal reset release timing wrong");
	AST_SWAP: assert property ($rose(core_rst_b_out) |-> !pins_irq_out[*8] ##[1:30] pins_irq_out)
		else $error("pin swap delay wrong");
	AST_GATE: assert property (!pins_irq_out |-> !ext_irq_a_out && !ext_irq_b_out)
		else $error("request seen before pin swap");
	AST_MODE_WR: assert property (pins_irq_out && mode_wr_in |=> mode_out == $past(mode_wdata_in))
		else $error("mode write lost");
	AST_LEVEL_A: assert property (pins_irq_out && trig_a_in == MLEIR_TRIG_LEVEL ##0 !mode_select_a_in [*3]
		|-> ##[1:2] ext_irq_a_out)
		else $error("level request A missed");
	AST_IDLE_B: assert property ((trig_b_in == MLEIR_TRIG_LEVEL && mode_select_b_in) [*4] |-> !ext_irq_b_out)
		else $error("request B without low pin");
	AST_EDGE_HOLD: assert property (ext_irq_a_out && trig_a_in == MLEIR_TRIG_FALL && !ack_a_in |=> ext_irq_a_out)
		else $error("edge request A dropped before ack");
	AST_STOP: assert property (stop_in && !stopped_out |=> stopped_out)
		else $error("stop not entered");
	AST_WAKE: assert property (stopped_out && ext_irq_a_out |=> s_wake)
		else $error("no wake from stop");
endmodule

// ==== verification/mleir_ext_dev.sv ====
// external requester and reset source beside the pins
// assumes pins pulled high when not driven low
`timescale 1ns/100ps
module mleir_ext_dev
	import mleir_pkg::*;
(
	input  wire logic        rst_b_in,                     // reset source, active low
	input  wire logic        boot_in,                      // drive mode straps
	input  wire mleir_mode_s strap_in,                     // mode strap value
	input  wire logic [1:0]  req_in,                       // {b,a} service wanted
	input  wire logic        dbg_only_in,                  // reset core only
	output logic             pin_a_out,                    // pin A
	output logic             pin_b_out,                    // pin B
	output logic             test_reset_debug_event_b_out  // test reset, active low
);
	assign pin_a_out = boot_in ? strap_in.mode_a : !req_in[0];
	assign pin_b_out = boot_in ? strap_in.mode_b : !req_in[1];
	assign test_reset_debug_event_b_out = rst_b_in | dbg_only_in;
endmodule

// ==== verification/test_mleir_top.sv ====
// self-checking bench for mleir_top
// assumes checker and external device model compiled first
`timescale 1ns/100ps
module test_mleir_top;
	import mleir_pkg::*;
	logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, boot = 1'b1, dbg_only = 1'b0, mode_select_a_in, mode_select_b_in;
	logic        ack_a_in = 1'b0, ack_b_in = 1'b0, mode_wr_in = 1'b0, stop_in = 1'b0, trst_b;
	logic [1:0]  req = 2'h0;
	mleir_trig_e trig_a_in = MLEIR_TRIG_LEVEL, trig_b_in = MLEIR_TRIG_LEVEL;
	mleir_mode_s strap = 2'h1, mode_wdata_in = 2'h0, mode_out;
	logic        ext_irq_a_out, ext_irq_b_out, stopped_out, wake_out, core_rst_b_out, pins_irq_out;
	int          num_errors = 0, n_tests = 0, cyc = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	mleir_top i_mleir_top (.*);
	mleir_ext_dev i_mleir_ext_dev (.rst_b_in(rst_b_in), .boot_in(boot), .strap_in(strap), .req_in(req),
		.dbg_only_in(dbg_only), .pin_a_out(mode_select_a_in), .pin_b_out(mode_select_b_in),
		.test_reset_debug_event_b_out(trst_b));
	task automatic final_report;
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			final_report;
		end
	end
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic t_boot(input mleir_mode_s m);
		rst_b_in = 1'b0;
		boot = 1'b1;
		strap = m;
		cyc_n(5);
		chk({1'b0, core_rst_b_out}, 2'h0);
		rst_b_in = 1'b1;
		cyc_n(20);
		chk({ext_irq_b_out, pins_irq_out}, 2'h0);
		for (int k = 0; k < 10 && !pins_irq_out; k++) cyc_n(1);
		chk({1'b0, pins_irq_out}, 2'h1);
		chk(mode_out, m);
		boot = 1'b0;
		cyc_n(4);
	endtask
	task automatic t_level;
		for (int i = 0; i < 2; i++) begin
			req[i] = 1'b1;
			cyc_n(4);
			chk({ext_irq_b_out, ext_irq_a_out}, 2'h1 << i);
			req[i] = 1'b0;
			cyc_n(4);
			chk({ext_irq_b_out, ext_irq_a_out}, 2'h0);
		end
	endtask
	task automatic t_edge;
		trig_a_in = MLEIR_TRIG_FALL;
		trig_b_in = MLEIR_TRIG_FALL;
		req = 2'h3;
		cyc_n(2);
		req = 2'h0;
		cyc_n(6);
		chk({ext_irq_b_out, ext_irq_a_out}, 2'h3);
		ack_a_in = 1'b1;
		cyc_n(1);
		ack_a_in = 1'b0;
		chk({ext_irq_b_out, ext_irq_a_out}, 2'h2);
		ack_b_in = 1'b1;
		cyc_n(1);
		ack_b_in = 1'b0;
		chk({ext_irq_b_out, ext_irq_a_out}, 2'h0);
		trig_a_in = MLEIR_TRIG_LEVEL;
		trig_b_in = MLEIR_TRIG_LEVEL;
	endtask
	task automatic t_stop;
		logic w;
		w = 1'b0;
		stop_in = 1'b1;
		cyc_n(1);
		stop_in = 1'b0;
		chk({1'b0, stopped_out}, 2'h1);
		req = 2'h1;
		repeat (8) begin
			cyc_n(1);
			w = w | wake_out;
		end
		req = 2'h0;
		chk({w, stopped_out}, 2'h2);
	endtask
	initial begin
		t_boot(2'h1);
		t_level;
		t_edge;
		mode_wdata_in = 2'h3;
		mode_wr_in = 1'b1;
		cyc_n(1);
		mode_wr_in = 1'b0;
		chk(mode_out, 2'h3);
		t_stop;
		dbg_only = 1'b1;
		t_boot(2'h2);
		final_report;
	end
endmodule
bind mleir_top mleir_top_chk i_mleir_top_chk (.*);
